// File: logic/acc_pkg.sv
// Shared constants of the channel trim register bank: address map,
// field positions, reset values and correction arithmetic.
// Assumes an 8-bit register address and 16-bit register data.
package acc_pkg;

  // ----------------------------------------------------------------
  // Register port geometry
  // ----------------------------------------------------------------
  localparam int ACC_ADDR_W = 8;
  localparam int ACC_DATA_W = 16;
  localparam int ACC_SAMPLE_W = 24;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_CH1_OFS_LO_ADDR = 8'h10;
  localparam logic [7:0] ACC_CH1_GAIN_HI_ADDR = 8'h11;
  localparam logic [7:0] ACC_CH1_GAIN_LO_ADDR = 8'h12;
  localparam logic [7:0] ACC_CH2_CONFIG_ADDR = 8'h13;
  localparam logic [7:0] ACC_CH2_OFS_HI_ADDR = 8'h14;
  localparam logic [7:0] ACC_CH2_OFS_LO_ADDR = 8'h15;
  localparam logic [7:0] ACC_CH2_GAIN_HI_ADDR = 8'h16;
  localparam logic [7:0] ACC_CH2_GAIN_LO_ADDR = 8'h17;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACC_TRIM_BYTE_LSB = 8;
  localparam int ACC_TRIM_BYTE_MSB = 15;
  localparam int ACC_PHASE_LSB = 6;
  localparam int ACC_PHASE_MSB = 15;
  localparam int ACC_PHASE_W = 10;
  localparam int ACC_DC_OFF_BIT = 2;
  localparam int ACC_SEL_LSB = 0;
  localparam int ACC_SEL_MSB = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ACC_GAIN_HI_RST = 16'h8000;
  localparam logic [15:0] ACC_OFS_HI_RST = 16'h0000;
  localparam logic [7:0] ACC_LO_BYTE_RST = 8'h00;
  localparam logic [9:0] ACC_PHASE_RST = 10'h000;
  localparam logic [2:0] ACC_CFG_RESV = 3'h0;
  localparam logic [7:0] ACC_RESV_BYTE = 8'h00;
  localparam logic [15:0] ACC_UNMAPPED_DATA = 16'h0000;

  // ----------------------------------------------------------------
  // Correction arithmetic: gain 800000h is unity, so 23 fraction bits
  // ----------------------------------------------------------------
  localparam logic [23:0] ACC_GAIN_UNITY = 24'h800000;
  localparam int ACC_PIPE_LAT = 2;

  typedef enum logic [1:0]
  {
    ACC_SEL_PINS = 2'b00,
    ACC_SEL_SHORTED = 2'b01,
    ACC_SEL_TEST_POS = 2'b10,
    ACC_SEL_TEST_NEG = 2'b11
  } acc_input_sel_e;

endpackage

// File: logic/acc_trim_apply.sv
// Applies one channel's offset and gain correction to its samples.
// Two pipeline stages; the trims are captured with the sample so a
// trim rewrite mid-flight never mixes old and new values.
`timescale 1ns/10ps
module acc_trim_apply
#(
  parameter int W = acc_pkg::ACC_SAMPLE_W
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_sample,
  input wire logic i_valid,
  input wire logic [W-1:0] i_offset,
  input wire logic [W-1:0] i_gain,
  output logic [W-1:0] o_data,
  output logic o_valid
);
  import acc_pkg::*;

  localparam int FRAC = W - 1;
  localparam int PW = 2 * W + 2;

  if (W < 2)
  begin : g_bad_width
    $error("acc_trim_apply needs W of at least 2");
  end

  typedef struct packed {
    logic v1;
    logic [W:0] sum1;
    logic [W-1:0] gain1;
    logic v2;
    logic [W-1:0] data2;
  } acc_pipe_s;

  acc_pipe_s s_r;
  acc_pipe_s s_nxt;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] scaled;

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.v1 = i_valid;
    // Sign-extended add cannot overflow the one extra bit
    s_nxt.sum1 = {i_sample[W-1], i_sample} + {i_offset[W-1], i_offset};
    s_nxt.gain1 = i_gain;
    // Gain is an unsigned fraction, so it enters the multiply as positive
    prod = PW'($signed(s_r.sum1) * $signed({1'b0, s_r.gain1}));
    scaled = prod >>> FRAC;
    s_nxt.v2 = s_r.v1;
    if (scaled[PW-1:FRAC] == {(PW-FRAC){scaled[FRAC]}})
    begin
      s_nxt.data2 = scaled[W-1:0];
    end
    else if (scaled[PW-1])
    begin
      s_nxt.data2 = {1'b1, {(W-1){1'b0}}};
    end
    else
    begin
      s_nxt.data2 = {1'b0, {(W-1){1'b1}}};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign o_data = s_r.data2;
  assign o_valid = s_r.v2;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence unity_in_s;
    i_valid && (i_gain == ACC_GAIN_UNITY[W-1:0]) && (i_offset == '0);
  endsequence

  unity_pass_a: assert property (unity_in_s |-> ##2 o_valid && o_data == $past(i_sample, 2))
    else $error("unity gain and zero offset altered the sample");

  lat_valid_a: assert property (o_valid == $past(i_valid, 2) || $past(!i_resetn, 2))
    else $error("corrected sample valid not two cycles after input");

endmodule

// File: logic/acc_trim_regs.sv
// Channel 1 and channel 2 trim and configuration registers, with the
// correction of both channels' conversion results.
// Assumes a plain register port, read data one cycle after the strobe,
// and channel 1's high offset word held by the neighbouring bank.
//
// What this block does
// - Offset high register is trim bits 23:8
// - Offset low bits 15:8 hold trim 7:0
// - Gain high register is trim bits 23:8
// - Gain is unsigned fraction below two
// - Gain high resets 8000h, low resets zero
// - Both offset registers reset to zero
// - Low register bits 7:0 read zero
// - Config bits 15:6 hold signed phase delay
// - Config bits 5:3 read zero
// - Config bit 2 overrides global DC filter
// - Config bits 1:0 select channel input
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
module acc_trim_regs
#(
  parameter int ADDR_W = acc_pkg::ACC_ADDR_W,
  parameter int SAMPLE_W = acc_pkg::ACC_SAMPLE_W
)
(
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [acc_pkg::ACC_DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [acc_pkg::ACC_DATA_W-1:0] O_RDATA,
  input wire logic [acc_pkg::ACC_DATA_W-1:0] I_CH1_OFFSET_TRIM_HIGH_WORD,
  input wire logic I_GLOBAL_DC_FILTER_SETTING,
  output logic [acc_pkg::ACC_PHASE_W-1:0] O_CH2_PHASE_DELAY,
  output logic O_CH2_DC_FILTER_OFF,
  output logic O_CH2_DC_FILTER_EN,
  output acc_pkg::acc_input_sel_e O_CH2_INPUT_SELECT,
  input wire logic [SAMPLE_W-1:0] I_CH1_SAMPLE,
  input wire logic I_CH1_VALID,
  input wire logic [SAMPLE_W-1:0] I_CH2_SAMPLE,
  input wire logic I_CH2_VALID,
  output logic [SAMPLE_W-1:0] O_CH1_CORRECTED,
  output logic O_CH1_CORRECTED_VALID,
  output logic [SAMPLE_W-1:0] O_CH2_CORRECTED,
  output logic O_CH2_CORRECTED_VALID
);
  import acc_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The map ends at 17h and the trim layout fixes a 24-bit word
  if (ADDR_W < 5 || ADDR_W > 8)
  begin : g_bad_addr
    $error("acc_trim_regs needs ADDR_W from 5 to 8");
  end
  if (SAMPLE_W != ACC_SAMPLE_W)
  begin : g_bad_sample
    $error("acc_trim_regs needs SAMPLE_W of 24");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ch1_offset_trim_low_byte;
    logic [15:0] ch1_gain_trim_high_word;
    logic [7:0] ch1_gain_trim_low_byte;
    logic [ACC_PHASE_W-1:0] ch2_phase_delay;
    logic ch2_dc_filter_off;
    acc_input_sel_e ch2_input_select;
    logic [15:0] ch2_offset_trim_high_word;
    logic [7:0] ch2_offset_trim_low_byte;
    logic [15:0] ch2_gain_trim_high_word;
    logic [7:0] ch2_gain_trim_low_byte;
    logic [15:0] rdata;
  } acc_regs_s;

  localparam acc_regs_s REGS_RST = '{
    ch1_offset_trim_low_byte: ACC_LO_BYTE_RST,
    ch1_gain_trim_high_word: ACC_GAIN_HI_RST,
    ch1_gain_trim_low_byte: ACC_LO_BYTE_RST,
    ch2_phase_delay: ACC_PHASE_RST,
    ch2_dc_filter_off: 1'b0,
    ch2_input_select: ACC_SEL_PINS,
    ch2_offset_trim_high_word: ACC_OFS_HI_RST,
    ch2_offset_trim_low_byte: ACC_LO_BYTE_RST,
    ch2_gain_trim_high_word: ACC_GAIN_HI_RST,
    ch2_gain_trim_low_byte: ACC_LO_BYTE_RST,
    rdata: ACC_UNMAPPED_DATA
  };

  acc_regs_s s_r;
  acc_regs_s s_nxt;
  logic [7:0] addr8;
  logic [7:0] wbyte;

  // Narrow ports are zero-extended so the 8-bit offsets compare cleanly
  assign addr8 = 8'(I_ADDR);
  assign wbyte = I_WDATA[ACC_TRIM_BYTE_MSB:ACC_TRIM_BYTE_LSB];

  // ----------------------------------------------------------------
  // Register writes and reads
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    if (I_WR)
    begin
      // Only the upper byte of a low register is stored; bits 7:0 are dropped
      if (addr8 == ACC_CH1_OFS_LO_ADDR)
      begin
        s_nxt.ch1_offset_trim_low_byte = wbyte;
      end
      else if (addr8 == ACC_CH1_GAIN_HI_ADDR)
      begin
        s_nxt.ch1_gain_trim_high_word = I_WDATA;
      end
      else if (addr8 == ACC_CH1_GAIN_LO_ADDR)
      begin
        s_nxt.ch1_gain_trim_low_byte = wbyte;
      end
      else if (addr8 == ACC_CH2_CONFIG_ADDR)
      begin
        s_nxt.ch2_phase_delay = I_WDATA[ACC_PHASE_MSB:ACC_PHASE_LSB];
        s_nxt.ch2_dc_filter_off = I_WDATA[ACC_DC_OFF_BIT];
        s_nxt.ch2_input_select = acc_input_sel_e'(I_WDATA[ACC_SEL_MSB:ACC_SEL_LSB]);
      end
      else if (addr8 == ACC_CH2_OFS_HI_ADDR)
      begin
        s_nxt.ch2_offset_trim_high_word = I_WDATA;
      end
      else if (addr8 == ACC_CH2_OFS_LO_ADDR)
      begin
        s_nxt.ch2_offset_trim_low_byte = wbyte;
      end
      else if (addr8 == ACC_CH2_GAIN_HI_ADDR)
      begin
        s_nxt.ch2_gain_trim_high_word = I_WDATA;
      end
      else if (addr8 == ACC_CH2_GAIN_LO_ADDR)
      begin
        s_nxt.ch2_gain_trim_low_byte = wbyte;
      end
    end

    // Read data stand for exactly one cycle, zero otherwise
    s_nxt.rdata = ACC_UNMAPPED_DATA;
    if (I_RD)
    begin
      if (addr8 == ACC_CH1_OFS_LO_ADDR)
      begin
        s_nxt.rdata = {s_r.ch1_offset_trim_low_byte, ACC_RESV_BYTE};
      end
      else if (addr8 == ACC_CH1_GAIN_HI_ADDR)
      begin
        s_nxt.rdata = s_r.ch1_gain_trim_high_word;
      end
      else if (addr8 == ACC_CH1_GAIN_LO_ADDR)
      begin
        s_nxt.rdata = {s_r.ch1_gain_trim_low_byte, ACC_RESV_BYTE};
      end
      else if (addr8 == ACC_CH2_CONFIG_ADDR)
      begin
        s_nxt.rdata = {s_r.ch2_phase_delay, ACC_CFG_RESV, s_r.ch2_dc_filter_off,
                       s_r.ch2_input_select};
      end
      else if (addr8 == ACC_CH2_OFS_HI_ADDR)
      begin
        s_nxt.rdata = s_r.ch2_offset_trim_high_word;
      end
      else if (addr8 == ACC_CH2_OFS_LO_ADDR)
      begin
        s_nxt.rdata = {s_r.ch2_offset_trim_low_byte, ACC_RESV_BYTE};
      end
      else if (addr8 == ACC_CH2_GAIN_HI_ADDR)
      begin
        s_nxt.rdata = s_r.ch2_gain_trim_high_word;
      end
      else if (addr8 == ACC_CH2_GAIN_LO_ADDR)
      begin
        s_nxt.rdata = {s_r.ch2_gain_trim_low_byte, ACC_RESV_BYTE};
      end
    end
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      s_r <= REGS_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  assign O_RDATA = s_r.rdata;
  assign O_CH2_PHASE_DELAY = s_r.ch2_phase_delay;
  assign O_CH2_DC_FILTER_OFF = s_r.ch2_dc_filter_off;
  // Per-channel disable can only turn the filter off, never force it on
  assign O_CH2_DC_FILTER_EN = I_GLOBAL_DC_FILTER_SETTING && !s_r.ch2_dc_filter_off;
  assign O_CH2_INPUT_SELECT = s_r.ch2_input_select;

  // ----------------------------------------------------------------
  // Correction datapath, one instance per channel
  // ----------------------------------------------------------------
  logic [1:0][SAMPLE_W-1:0] ch_sample;
  logic [1:0] ch_valid;
  logic [1:0][SAMPLE_W-1:0] ch_offset;
  logic [1:0][SAMPLE_W-1:0] ch_gain;
  logic [1:0][SAMPLE_W-1:0] ch_data;
  logic [1:0] ch_data_valid;

  assign ch_sample = {I_CH2_SAMPLE, I_CH1_SAMPLE};
  assign ch_valid = {I_CH2_VALID, I_CH1_VALID};
  assign ch_offset[0] = {I_CH1_OFFSET_TRIM_HIGH_WORD, s_r.ch1_offset_trim_low_byte};
  assign ch_offset[1] = {s_r.ch2_offset_trim_high_word, s_r.ch2_offset_trim_low_byte};
  assign ch_gain[0] = {s_r.ch1_gain_trim_high_word, s_r.ch1_gain_trim_low_byte};
  assign ch_gain[1] = {s_r.ch2_gain_trim_high_word, s_r.ch2_gain_trim_low_byte};

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    acc_trim_apply #(
      .W(SAMPLE_W)
    ) u_apply (
      .i_clk(I_CORE_CLK),
      .i_resetn(I_RESETN),
      .i_sample(ch_sample[ch]),
      .i_valid(ch_valid[ch]),
      .i_offset(ch_offset[ch]),
      .i_gain(ch_gain[ch]),
      .o_data(ch_data[ch]),
      .o_valid(ch_data_valid[ch])
    );
  end

  assign O_CH1_CORRECTED = ch_data[0];
  assign O_CH1_CORRECTED_VALID = ch_data_valid[0];
  assign O_CH2_CORRECTED = ch_data[1];
  assign O_CH2_CORRECTED_VALID = ch_data_valid[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);

  sequence rd_low_s;
    I_RD && (addr8 == ACC_CH1_OFS_LO_ADDR || addr8 == ACC_CH1_GAIN_LO_ADDR ||
             addr8 == ACC_CH2_OFS_LO_ADDR || addr8 == ACC_CH2_GAIN_LO_ADDR);
  endsequence

  sequence wr_rd_s(logic [7:0] a);
    I_WR && addr8 == a ##1 I_RD && !I_WR && addr8 == a;
  endsequence

  sequence wr_s(logic [7:0] a);
    I_WR && addr8 == a;
  endsequence

  low_resv_a: assert property (rd_low_s |=> O_RDATA[7:0] == ACC_RESV_BYTE)
    else $error("reserved low byte read nonzero");

  gain_reset_a: assert property ($past(!I_RESETN) |-> O_CH2_CORRECTED_VALID == 1'b0 &&
      ch_gain[0] == ACC_GAIN_UNITY && ch_gain[1] == ACC_GAIN_UNITY)
    else $error("gain trim not unity after reset");

  ofs_reset_a: assert property ($past(!I_RESETN) |-> ch_offset[1] == '0 &&
      s_r.ch1_offset_trim_low_byte == ACC_LO_BYTE_RST)
    else $error("offset trim not zero after reset");

  cfg_resv_a: assert property (I_RD && addr8 == ACC_CH2_CONFIG_ADDR |=> O_RDATA[5:3] == 3'h0)
    else $error("config reserved bits read nonzero");

  dc_filter_a: assert property (I_WR && addr8 == ACC_CH2_CONFIG_ADDR &&
      I_WDATA[ACC_DC_OFF_BIT] |=> O_CH2_DC_FILTER_OFF && !O_CH2_DC_FILTER_EN)
    else $error("DC filter stays on after per-channel disable");

  dc_follow_a: assert property (I_WR && addr8 == ACC_CH2_CONFIG_ADDR &&
      !I_WDATA[ACC_DC_OFF_BIT] |=> O_CH2_DC_FILTER_EN == I_GLOBAL_DC_FILTER_SETTING)
    else $error("DC filter enable does not follow global setting");

  gain_hi_rb_a: assert property (wr_rd_s(ACC_CH2_GAIN_HI_ADDR) |=>
      O_RDATA == $past(I_WDATA, 2))
    else $error("gain high word readback mismatch");

  gain_lo_rb_a: assert property (wr_rd_s(ACC_CH1_GAIN_LO_ADDR) |=>
      O_RDATA == {$past(I_WDATA[15:8], 2), 8'h00})
    else $error("gain low byte readback mismatch");

  ofs_hi_rb_a: assert property (wr_rd_s(ACC_CH2_OFS_HI_ADDR) |=>
      O_RDATA == $past(I_WDATA, 2))
    else $error("offset high word readback mismatch");

  ofs_join_a: assert property (wr_s(ACC_CH2_OFS_LO_ADDR) |=>
      ch_offset[1][7:0] == $past(I_WDATA[15:8]) &&
      ch_offset[1][23:8] == $past(s_r.ch2_offset_trim_high_word))
    else $error("offset low byte not joined under high word");

  gain_lo_join_a: assert property (wr_s(ACC_CH2_GAIN_LO_ADDR) |=>
      ch_gain[1][7:0] == $past(I_WDATA[15:8]) &&
      ch_gain[1][23:8] == $past(s_r.ch2_gain_trim_high_word))
    else $error("gain low byte not joined under high word");

  ch1_ofs_lo_a: assert property (wr_s(ACC_CH1_OFS_LO_ADDR) |=>
      ch_offset[0][7:0] == $past(I_WDATA[15:8]))
    else $error("channel 1 offset low byte not applied");

  ch1_gain_hi_a: assert property (wr_s(ACC_CH1_GAIN_HI_ADDR) |=>
      ch_gain[0][23:8] == $past(I_WDATA))
    else $error("channel 1 gain high word not applied");

  ch2_gain_hi_a: assert property (wr_s(ACC_CH2_GAIN_HI_ADDR) |=>
      ch_gain[1][23:8] == $past(I_WDATA))
    else $error("channel 2 gain high word not applied");

  ch2_ofs_hi_a: assert property (wr_s(ACC_CH2_OFS_HI_ADDR) |=>
      ch_offset[1][23:8] == $past(I_WDATA))
    else $error("channel 2 offset high word not applied");

  phase_wr_a: assert property (wr_s(ACC_CH2_CONFIG_ADDR) |=>
      O_CH2_PHASE_DELAY == $past(I_WDATA[15:6]) &&
      O_CH2_INPUT_SELECT == $past(I_WDATA[1:0]))
    else $error("config write did not reach phase or input select");

  cfg_rb_a: assert property (I_RD && addr8 == ACC_CH2_CONFIG_ADDR |=>
      O_RDATA[15:6] == $past(O_CH2_PHASE_DELAY) && O_RDATA[2] == $past(O_CH2_DC_FILTER_OFF) &&
      O_RDATA[1:0] == $past(O_CH2_INPUT_SELECT))
    else $error("config fields read back out of place");

  unmapped_a: assert property (I_RD && addr8 > ACC_CH2_GAIN_LO_ADDR |=> O_RDATA == 16'h0000)
    else $error("unmapped read returned data");

  idle_zero_a: assert property (!I_RD |=> O_RDATA == 16'h0000)
    else $error("read data stands outside its cycle");

endmodule

// File: verification/tb.sv
// Self-checking bench for the channel trim register bank.
// Assumes the plain register port of acc_trim_regs and its two-cycle
// correction pipeline; the bench drives every input itself.
`timescale 1ns/10ps
module tb;
  import acc_pkg::*;

  logic clk;
  logic resetn;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [15:0] ch1_hi;
  logic glob;
  logic [9:0] phase;
  logic dc_off;
  logic dc_en;
  acc_input_sel_e sel;
  logic [23:0] s1;
  logic [23:0] s2;
  logic v1;
  logic v2;
  logic [23:0] o1;
  logic [23:0] o2;
  logic ov1;
  logic ov2;
  int errors;
  int total_checks;
  logic [15:0] cw;
  logic [15:0] pats [2] = '{16'hFFFF, 16'hA5C3};
  logic [7:0] addr_tab [8] = '{ACC_CH1_OFS_LO_ADDR, ACC_CH1_GAIN_HI_ADDR, ACC_CH1_GAIN_LO_ADDR,
    ACC_CH2_CONFIG_ADDR, ACC_CH2_OFS_HI_ADDR, ACC_CH2_OFS_LO_ADDR, ACC_CH2_GAIN_HI_ADDR,
    ACC_CH2_GAIN_LO_ADDR};
  logic [15:0] rst_tab [8] = '{16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h8000, 16'h0000};
  // Writable bits of each register; reserved bits must read back as zero
  logic [15:0] mask_tab [8] = '{16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC7, 16'hFFFF, 16'hFF00,
    16'hFFFF, 16'hFF00};

  acc_trim_regs DUT
  (
    .I_CORE_CLK(clk),
    .I_RESETN(resetn),
    .I_ADDR(addr),
    .I_WDATA(wdata),
    .I_WR(wr),
    .I_RD(rd),
    .O_RDATA(rdata),
    .I_CH1_OFFSET_TRIM_HIGH_WORD(ch1_hi),
    .I_GLOBAL_DC_FILTER_SETTING(glob),
    .O_CH2_PHASE_DELAY(phase),
    .O_CH2_DC_FILTER_OFF(dc_off),
    .O_CH2_DC_FILTER_EN(dc_en),
    .O_CH2_INPUT_SELECT(sel),
    .I_CH1_SAMPLE(s1),
    .I_CH1_VALID(v1),
    .I_CH2_SAMPLE(s2),
    .I_CH2_VALID(v2),
    .O_CH1_CORRECTED(o1),
    .O_CH1_CORRECTED_VALID(ov1),
    .O_CH2_CORRECTED(o2),
    .O_CH2_CORRECTED_VALID(ov2)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task end_of_test;
    if (errors == 0 && total_checks > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data must stand in the one cycle after the strobe only
  task rd_reg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, exp}, "read data");
    @(posedge clk);
    #1 chk({8'h00, rdata}, 24'h000000, "read data after its cycle");
  endtask

  // Write then read the same register with no idle cycle between
  task wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, exp}, "read right after write");
  endtask

  // Reference correction: signed sample plus signed offset, times an
  // unsigned gain with 800000h as unity, floored and saturated
  function automatic logic [23:0] corr(input logic [23:0] s, input logic [23:0] o,
    input logic [23:0] g);
    longint t;
    t = (longint'($signed(s)) + longint'($signed(o))) * longint'({40'h0, g});
    t = t >>> 23;
    if (t > longint'(64'sh7FFFFF))
      return 24'h7FFFFF;
    if (t < -longint'(64'sh800000))
      return 24'h800000;
    return t[23:0];
  endfunction

  task smp(input logic ch2, input logic [23:0] s, input logic [23:0] exp);
    @(posedge clk);
    if (ch2)
    begin
      s2 <= s;
      v2 <= 1'b1;
    end
    else
    begin
      s1 <= s;
      v1 <= 1'b1;
    end
    @(posedge clk);
    v1 <= 1'b0;
    v2 <= 1'b0;
    #1 chk({23'h0, ch2 ? ov2 : ov1}, 24'h000000, "result too early");
    @(posedge clk);
    #1 chk({23'h0, ch2 ? ov2 : ov1}, 24'h000001, "result valid missing");
    chk(ch2 ? o2 : o1, exp, "corrected sample");
    @(posedge clk);
    #1 chk({23'h0, ch2 ? ov2 : ov1}, 24'h000000, "result valid too long");
  endtask

  task check_reset;
    for (int i = 0; i < 8; i++)
      rd_reg(addr_tab[i], rst_tab[i]);
    chk({14'h0, phase}, 24'h000000, "phase delay after reset");
    chk({23'h0, dc_off}, 24'h000000, "filter off after reset");
    chk({22'h0, sel}, {22'h0, ACC_SEL_PINS}, "input select after reset");
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("BAD %0t run did not finish", $time);
    end_of_test;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    errors = 0;
    total_checks = 0;
    resetn = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    ch1_hi = 16'h0000;
    glob = 1'b1;
    s1 = 24'h000000;
    s2 = 24'h000000;
    v1 = 1'b0;
    v2 = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    check_reset();
    // Reset trims leave samples untouched
    smp(1'b0, 24'h123456, 24'h123456);
    smp(1'b1, 24'hF00001, 24'hF00001);
    // Field packing and reserved bits, each write followed by its read
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 8; i++)
      begin
        wr_reg(addr_tab[i], pats[p]);
        rd_reg(addr_tab[i], pats[p] & mask_tab[i]);
      end
    // Back-to-back write and read
    wr_rd(ACC_CH2_GAIN_HI_ADDR, 16'h1234, 16'h1234);
    wr_rd(ACC_CH1_GAIN_LO_ADDR, 16'h5A3C, 16'h5A00);
    wr_rd(ACC_CH2_OFS_HI_ADDR, 16'hC001, 16'hC001);
    // Unmapped place and the high offset word kept outside this bank
    wr_reg(8'h18, 16'hFFFF);
    rd_reg(8'h18, 16'h0000);
    rd_reg(8'h0F, 16'h0000);
    // Every input selection, both filter settings, both phase signs
    for (int k = 0; k < 4; k++)
    begin
      cw = {(k[0] ? 10'h200 : 10'h1FF), 3'h7, k[0], k[1:0]};
      wr_reg(ACC_CH2_CONFIG_ADDR, cw);
      #1 chk({14'h0, phase}, {14'h0, cw[15:6]}, "phase delay");
      chk({23'h0, dc_off}, {23'h0, k[0]}, "filter off");
      chk({22'h0, sel}, {22'h0, k[1:0]}, "input select");
      rd_reg(ACC_CH2_CONFIG_ADDR, cw & 16'hFFC7);
      @(posedge clk);
      glob <= 1'b1;
      #1 chk({23'h0, dc_en}, {23'h0, ~k[0]}, "filter enable, global on");
      @(posedge clk);
      glob <= 1'b0;
      #1 chk({23'h0, dc_en}, 24'h000000, "filter enable, global off");
    end
    // Channel 2: offset 000180h, gain 400080h; low byte of writes ignored
    wr_reg(ACC_CH2_OFS_HI_ADDR, 16'h0001);
    wr_reg(ACC_CH2_OFS_LO_ADDR, 16'h80FF);
    wr_reg(ACC_CH2_GAIN_HI_ADDR, 16'h4000);
    wr_reg(ACC_CH2_GAIN_LO_ADDR, 16'h8055);
    smp(1'b1, 24'h001000, corr(24'h001000, 24'h000180, 24'h400080));
    // Channel 1: offset -1 from outside word, gain just under two
    @(posedge clk);
    ch1_hi <= 16'hFFFF;
    wr_reg(ACC_CH1_OFS_LO_ADDR, 16'hFF00);
    wr_reg(ACC_CH1_GAIN_HI_ADDR, 16'hFFFF);
    wr_reg(ACC_CH1_GAIN_LO_ADDR, 16'hFF00);
    smp(1'b0, 24'h000100, corr(24'h000100, 24'hFFFFFF, 24'hFFFFFF));
    smp(1'b0, 24'h7FFFFF, corr(24'h7FFFFF, 24'hFFFFFF, 24'hFFFFFF));
    smp(1'b0, 24'hC00000, corr(24'hC00000, 24'hFFFFFF, 24'hFFFFFF));
    // Reset in mid-run restores every register
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    check_reset();
    end_of_test;
  end
endmodule
